// *** adsc_clk_div.sv ***
`timescale 1ns/1ps
module adsc_clk_div
   #(parameter int DIV = 4)
   (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   // run control and divided clock
   input  wire logic run_in,
   output logic      div_out
   );

   localparam int HALF = DIV / 2;
   localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;

   logic [CW-1:0] cnt_q;

   generate
      if ((DIV < 2) || ((DIV % 2) != 0))
      begin : g_bad_div
         $error("divider must be even and at least two");
      end
   endgenerate

   // ****************************************************************
   // even divider; held low and restarted while stopped
   // ****************************************************************
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in || !run_in)
      begin
         cnt_q   <= '0;
         div_out <= 1'b0;
      end
      else if (cnt_q == CW'(HALF - 1))
      begin
         cnt_q   <= '0;
         div_out <= !div_out;
      end
      else
      begin
         cnt_q   <= cnt_q + CW'(1);
      end
   end
endmodule : adsc_clk_div

// *** adsc_pkg.sv ***
package adsc_pkg;
   // ****************************************************************
   // register port
   // ****************************************************************
   localparam int          ADSC_ADDR_W          = 4;
   localparam int          ADSC_DATA_W          = 16;
   localparam logic [3:0]  ADSC_FINE_OFFSET     = 4'hD;
   localparam logic [3:0]  ADSC_SYNC_OFFSET     = 4'hE;
   localparam logic [15:0] ADSC_FINE_RESET      = 16'h0000;
   localparam logic [15:0] ADSC_SYNC_RESET      = 16'h0003;
   localparam logic [15:0] ADSC_UNMAPPED_DATA   = 16'h0000;

   // ****************************************************************
   // fine adjust register fields
   // ****************************************************************
   localparam int          ADSC_FINE_CODE_MSB   = 15;
   localparam int          ADSC_FINE_CODE_LSB   = 10;
   localparam int          ADSC_FINE_CODE_W     = 6;
   localparam int          ADSC_OVR_BIT         = 8;
   localparam int          ADSC_COARSE_CODE_W   = 12;

   // ****************************************************************
   // synchronisation register fields
   // ****************************************************************
   localparam int          ADSC_REF_DLY_MSB     = 15;
   localparam int          ADSC_REF_DLY_LSB     = 7;
   localparam int          ADSC_REF_DLY_W       = 9;
   localparam int          ADSC_DUAL_EDGE_BIT   = 6;
   localparam int          ADSC_PHASE_MSB       = 4;
   localparam int          ADSC_PHASE_LSB       = 3;
   localparam int          ADSC_FOLLOWER_BIT    = 2;
   localparam int          ADSC_REF_OUT_DIS_BIT = 1;
   localparam int          ADSC_RST_BLOCK_BIT   = 0;

   // ****************************************************************
   // delay and phase figures
   // ****************************************************************
   localparam logic [8:0]  ADSC_REF_DLY_MAX     = 9'h13F;
   localparam int          ADSC_REF_DLY_MAX_PS  = 1200;
   localparam int          ADSC_PS_W            = 11;
   localparam int          ADSC_DEG_W           = 9;
   localparam logic [8:0]  ADSC_DEG_0           = 9'h000;
   localparam logic [8:0]  ADSC_DEG_90          = 9'h05A;
   localparam logic [8:0]  ADSC_DEG_180         = 9'h0B4;
   localparam logic [8:0]  ADSC_DEG_270         = 9'h10E;
   localparam int          ADSC_REF_DIV         = 4;
endpackage : adsc_pkg

// *** adsc_sync2.sv ***
`timescale 1ns/1ps
module adsc_sync2
   #(parameter int W = 1)
   (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   // asynchronous level and its synchronised copy
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
   );

   logic [W-1:0] meta_q;

   // ****************************************************************
   // two-stage synchroniser; first stage feeds only the second
   // ****************************************************************
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : adsc_sync2

// *** adsc_top.sv ***
// Function
// - fine delay code refines the coarse code for the sampling clock delay.
// - coarse-register enable set to one applies coarse and fine codes.
// - override enable set to one also enables aperture adjust.
// - while override enable is set, coarse-register enable is ignored.
// - nine-bit reference delay code maps zero to 1200 ps at 319.
// - codes of 319 and above give the maximum delay.
// - dual-edge enable at one selects dual-edge sampling on one clock.
// - in dual-edge mode I and Q sample 180 degrees apart.
// - phase select codes give 0, 90, 180 or 270 degrees.
// - follower enable at one syncs divided clocks to received reference; the code only sets follower_mode_enable_out and clears master_mode_out.
// - follower enable at zero makes the device the master.
// - reference output disable at zero drives clock/4 on both outputs.
// - reference output disable acts alike in master and follower mode.
// - reset block bit at one keeps output-clock reset input disabled.
// - reset block bit at zero enables output-clock reset input.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module adsc_top
   import adsc_pkg::*;
   (
   // clock and reset
   input  wire logic                          mclk_in,
   input  wire logic                          nrst_in,
   // register port
   input  wire logic [ADSC_ADDR_W-1:0]        reg_addr_in,
   input  wire logic [ADSC_DATA_W-1:0]        reg_wdata_in,
   input  wire logic                          reg_wr_in,
   input  wire logic                          reg_rd_in,
   output logic      [ADSC_DATA_W-1:0]        reg_rdata_out,
   // coarse register fields, same clock
   input  wire logic [ADSC_COARSE_CODE_W-1:0] coarse_delay_code_in,
   input  wire logic                          aperture_adjust_enable_in,
   // aperture delay controls
   output logic                               aperture_adjust_active_out,
   output logic      [ADSC_COARSE_CODE_W-1:0] coarse_delay_apply_out,
   output logic      [ADSC_FINE_CODE_W-1:0]   fine_delay_apply_out,
   // reference clock delay and phase
   output logic      [ADSC_REF_DLY_W-1:0]     ref_clock_delay_code_out,
   output logic      [ADSC_PS_W-1:0]          ref_clock_delay_ps_out,
   output logic      [1:0]                    ref_phase_select_out,
   output logic      [ADSC_DEG_W-1:0]         ref_phase_deg_out,
   // sampling mode
   output logic                               dual_edge_iq_mode_out,
   output logic      [ADSC_DEG_W-1:0]         q_phase_offset_deg_out,
   output logic                               follower_mode_enable_out,
   output logic                               master_mode_out,
   // reference clock outputs
   output logic                               sync_ref_clock_out_a_out,
   output logic                               sync_ref_clock_out_b_out,
   output logic                               sync_ref_drive_en_out,
   // output-clock reset
   input  wire logic                          output_clock_reset_input_in,
   output logic                               output_clock_reset_out
   );

   // ****************************************************************
   // functions
   // ****************************************************************
   function automatic logic hit(input logic [ADSC_ADDR_W-1:0] a,
                                input logic [ADSC_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic logic [ADSC_DEG_W-1:0] phase_deg(input logic [1:0] sel);
      case (sel)
         2'b00:   phase_deg = ADSC_DEG_0;
         2'b01:   phase_deg = ADSC_DEG_90;
         2'b10:   phase_deg = ADSC_DEG_180;
         default: phase_deg = ADSC_DEG_270;
      endcase
   endfunction : phase_deg

   // linear map of the clamped code onto picoseconds
   function automatic logic [ADSC_PS_W-1:0] code_to_ps(
                                input logic [ADSC_REF_DLY_W-1:0] c);
      logic [19:0] prod;
      prod       = 20'(c) * 20'(ADSC_REF_DLY_MAX_PS);
      code_to_ps = ADSC_PS_W'(prod / 20'(ADSC_REF_DLY_MAX));
   endfunction : code_to_ps

   // ****************************************************************
   // register storage
   // ****************************************************************
   logic [ADSC_DATA_W-1:0]        fine_reg_q;
   logic [ADSC_DATA_W-1:0]        sync_reg_q;
   logic [ADSC_FINE_CODE_W-1:0]   fine_code;
   logic                          ovr_en;
   logic [ADSC_REF_DLY_W-1:0]     ref_dly_code;
   logic [ADSC_REF_DLY_W-1:0]     ref_dly_sat;
   logic [1:0]                    phase_sel;
   logic                          dual_edge_en;
   logic                          follower_en;
   logic                          ref_out_dis;
   logic                          rst_block;
   logic                          adj_active;
   logic                          div_clk;
   logic                          rst_pin_sync;

   // reserved bits are stored as written so read-back matches the write
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
         fine_reg_q <= ADSC_FINE_RESET;
      else if (reg_wr_in && hit(reg_addr_in, ADSC_FINE_OFFSET))
         fine_reg_q <= reg_wdata_in;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
         sync_reg_q <= ADSC_SYNC_RESET;
      else if (reg_wr_in && hit(reg_addr_in, ADSC_SYNC_OFFSET))
         sync_reg_q <= reg_wdata_in;
   end

   // ****************************************************************
   // read port: data in the cycle after the strobe only
   // ****************************************************************
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
         reg_rdata_out <= ADSC_UNMAPPED_DATA;
      else if (reg_rd_in && hit(reg_addr_in, ADSC_FINE_OFFSET))
         reg_rdata_out <= fine_reg_q;
      else if (reg_rd_in && hit(reg_addr_in, ADSC_SYNC_OFFSET))
         reg_rdata_out <= sync_reg_q;
      else
         reg_rdata_out <= ADSC_UNMAPPED_DATA;
   end

   // ****************************************************************
   // field decode
   // ****************************************************************
   assign fine_code    = fine_reg_q[ADSC_FINE_CODE_MSB:ADSC_FINE_CODE_LSB];
   assign ovr_en       = fine_reg_q[ADSC_OVR_BIT];
   assign ref_dly_code = sync_reg_q[ADSC_REF_DLY_MSB:ADSC_REF_DLY_LSB];
   assign phase_sel    = sync_reg_q[ADSC_PHASE_MSB:ADSC_PHASE_LSB];
   assign dual_edge_en = sync_reg_q[ADSC_DUAL_EDGE_BIT];
   assign follower_en  = sync_reg_q[ADSC_FOLLOWER_BIT];
   assign ref_out_dis  = sync_reg_q[ADSC_REF_OUT_DIS_BIT];
   assign rst_block    = sync_reg_q[ADSC_RST_BLOCK_BIT];

   // override decides alone; the coarse enable only counts without it
   assign adj_active   = ovr_en ? 1'b1 : aperture_adjust_enable_in;
   assign ref_dly_sat  = (ref_dly_code >= ADSC_REF_DLY_MAX) ?
                         ADSC_REF_DLY_MAX : ref_dly_code;

   // ****************************************************************
   // aperture delay outputs
   // ****************************************************************
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         aperture_adjust_active_out <= 1'b0;
         coarse_delay_apply_out     <= '0;
         fine_delay_apply_out       <= '0;
      end
      else
      begin
         aperture_adjust_active_out <= adj_active;
         coarse_delay_apply_out     <= adj_active ? coarse_delay_code_in : '0;
         fine_delay_apply_out       <= adj_active ? fine_code : '0;
      end
   end

   // ****************************************************************
   // reference delay, phase and sampling mode outputs
   // ****************************************************************
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         ref_clock_delay_code_out <= '0;
         ref_clock_delay_ps_out   <= '0;
         ref_phase_select_out     <= '0;
         ref_phase_deg_out        <= ADSC_DEG_0;
      end
      else
      begin
         ref_clock_delay_code_out <= ref_dly_sat;
         ref_clock_delay_ps_out   <= code_to_ps(ref_dly_sat);
         ref_phase_select_out     <= phase_sel;
         ref_phase_deg_out        <= phase_deg(phase_sel);
      end
   end

   // dual-edge mode also needs bits at address zero, held elsewhere
   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         dual_edge_iq_mode_out  <= 1'b0;
         q_phase_offset_deg_out <= ADSC_DEG_0;
      end
      else
      begin
         dual_edge_iq_mode_out  <= dual_edge_en;
         q_phase_offset_deg_out <= dual_edge_en ? ADSC_DEG_180 : ADSC_DEG_0;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         follower_mode_enable_out <= 1'b0;
         master_mode_out          <= 1'b1;
      end
      else
      begin
         follower_mode_enable_out <= follower_en;
         master_mode_out          <= !follower_en;
      end
   end

   // ****************************************************************
   // reference clock outputs
   // ****************************************************************
   // the divider does not look at the role bit at all
   adsc_clk_div #(.DIV(ADSC_REF_DIV)) u_ref_div (
      .clk_in  (mclk_in),
      .nrst_in (nrst_in),
      .run_in  (!ref_out_dis),
      .div_out (div_clk)
   );

   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
      begin
         sync_ref_clock_out_a_out <= 1'b0;
         sync_ref_clock_out_b_out <= 1'b0;
         sync_ref_drive_en_out    <= 1'b0;
      end
      else
      begin
         sync_ref_clock_out_a_out <= div_clk && !ref_out_dis;
         sync_ref_clock_out_b_out <= div_clk && !ref_out_dis;
         sync_ref_drive_en_out    <= !ref_out_dis;
      end
   end

   // ****************************************************************
   // output-clock reset input
   // ****************************************************************
   adsc_sync2 #(.W(1)) u_rst_sync (
      .clk_in   (mclk_in),
      .nrst_in  (nrst_in),
      .async_in (output_clock_reset_input_in),
      .sync_out (rst_pin_sync)
   );

   always_ff @(posedge mclk_in)
   begin
      if (!nrst_in)
         output_clock_reset_out <= 1'b0;
      else
         output_clock_reset_out <= rst_pin_sync && !rst_block;
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   sequence s_ref_running;
      (!ref_out_dis)[*8];
   endsequence

   sequence s_reset_req;
      (!rst_block && output_clock_reset_input_in)[*4];
   endsequence

   property p_override_wins;
      @(posedge mclk_in) disable iff (!nrst_in)
      (ovr_en && !aperture_adjust_enable_in) |=>
         (aperture_adjust_active_out && fine_delay_apply_out == $past(fine_code));
   endproperty
   a_override_wins: assert property (p_override_wins)
      else $error("override did not enable aperture adjust");

   property p_coarse_enable;
      @(posedge mclk_in) disable iff (!nrst_in)
      (!ovr_en && aperture_adjust_enable_in) |=>
         (aperture_adjust_active_out &&
          coarse_delay_apply_out == $past(coarse_delay_code_in));
   endproperty
   a_coarse_enable: assert property (p_coarse_enable)
      else $error("coarse enable did not apply delay codes");

   property p_fine_gated;
      @(posedge mclk_in) disable iff (!nrst_in)
      (!ovr_en && !aperture_adjust_enable_in) |=>
         (!aperture_adjust_active_out && fine_delay_apply_out == '0 &&
          coarse_delay_apply_out == '0);
   endproperty
   a_fine_gated: assert property (p_fine_gated)
      else $error("delay codes applied while adjust disabled");

   property p_ref_saturate;
      @(posedge mclk_in) disable iff (!nrst_in)
      (ref_dly_code >= ADSC_REF_DLY_MAX) |=>
         (ref_clock_delay_code_out == ADSC_REF_DLY_MAX &&
          ref_clock_delay_ps_out == ADSC_PS_W'(ADSC_REF_DLY_MAX_PS));
   endproperty
   a_ref_saturate: assert property (p_ref_saturate)
      else $error("reference delay not saturated");

   property p_ref_zero;
      @(posedge mclk_in) disable iff (!nrst_in)
      (ref_dly_code == '0) |=> (ref_clock_delay_ps_out == '0);
   endproperty
   a_ref_zero: assert property (p_ref_zero)
      else $error("zero code gave nonzero delay");

   property p_dual_edge;
      @(posedge mclk_in) disable iff (!nrst_in)
      $rose(dual_edge_en) |=>
         (dual_edge_iq_mode_out && q_phase_offset_deg_out == ADSC_DEG_180);
   endproperty
   a_dual_edge: assert property (p_dual_edge)
      else $error("dual-edge mode not entered");

   property p_phase_quarter;
      @(posedge mclk_in) disable iff (!nrst_in)
      (phase_sel == 2'b01) |=> (ref_phase_deg_out == ADSC_DEG_90);
   endproperty
   a_phase_quarter: assert property (p_phase_quarter)
      else $error("phase code one not 90 degrees");

   property p_role;
      @(posedge mclk_in) disable iff (!nrst_in)
      ##1 (follower_mode_enable_out != master_mode_out) &&
          (follower_mode_enable_out == $past(follower_en));
   endproperty
   a_role: assert property (p_role)
      else $error("master and follower roles inconsistent");

   property p_ref_off;
      @(posedge mclk_in) disable iff (!nrst_in)
      ref_out_dis[*2] |=>
         (!sync_ref_clock_out_a_out && !sync_ref_clock_out_b_out &&
          !sync_ref_drive_en_out);
   endproperty
   a_ref_off: assert property (p_ref_off)
      else $error("reference outputs active while disabled");

   property p_ref_quarter;
      @(posedge mclk_in) disable iff (!nrst_in)
      s_ref_running |->
         (sync_ref_clock_out_a_out != $past(sync_ref_clock_out_a_out, 2) &&
          sync_ref_clock_out_a_out == sync_ref_clock_out_b_out &&
          sync_ref_drive_en_out);
   endproperty
   a_ref_quarter: assert property (p_ref_quarter)
      else $error("reference outputs not at quarter rate");

   property p_reset_blocked;
      @(posedge mclk_in) disable iff (!nrst_in)
      rst_block |=> !output_clock_reset_out;
   endproperty
   a_reset_blocked: assert property (p_reset_blocked)
      else $error("output-clock reset passed while blocked");

   property p_reset_passed;
      @(posedge mclk_in) disable iff (!nrst_in)
      s_reset_req |-> output_clock_reset_out;
   endproperty
   a_reset_passed: assert property (p_reset_passed)
      else $error("output-clock reset not passed");

   property p_readback;
      @(posedge mclk_in) disable iff (!nrst_in)
      (reg_wr_in && hit(reg_addr_in, ADSC_SYNC_OFFSET)) ##1
      (reg_rd_in && hit(reg_addr_in, ADSC_SYNC_OFFSET)) |=>
         (reg_rdata_out == $past(reg_wdata_in, 2));
   endproperty
   a_readback: assert property (p_readback)
      else $error("read-back differs from write");
endmodule : adsc_top

// *** tb_adsc_top.sv ***
`timescale 1ns/1ps
module tb_adsc_top;
   import adsc_pkg::*;
   `define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
      $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
   logic                    mclk_in = 0, nrst_in = 0, reg_wr_in = 0, reg_rd_in = 0;
   logic [ADSC_ADDR_W-1:0]  reg_addr_in = 0;
   logic [15:0]             reg_wdata_in = 0, rdata;
   logic [11:0]             cc_in = 0, cc_ap;
   logic                    en_in = 0, pin_in = 0, act, dual, flw, mst, ra, rb, drv, orst;
   logic [5:0]              fn_ap;
   logic [8:0]              dly, pdeg, qdeg;
   logic [10:0]             ps;
   logic [1:0]              psel;
   int                      num_errors = 0, cmp_count = 0;
   always #5 mclk_in = ~mclk_in;
   adsc_top u_adsc_top (.mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(rdata), .coarse_delay_code_in(cc_in), .aperture_adjust_enable_in(en_in),
      .aperture_adjust_active_out(act), .coarse_delay_apply_out(cc_ap),
      .fine_delay_apply_out(fn_ap), .ref_clock_delay_code_out(dly), .ref_clock_delay_ps_out(ps),
      .ref_phase_select_out(psel), .ref_phase_deg_out(pdeg), .dual_edge_iq_mode_out(dual),
      .q_phase_offset_deg_out(qdeg), .follower_mode_enable_out(flw), .master_mode_out(mst),
      .sync_ref_clock_out_a_out(ra), .sync_ref_clock_out_b_out(rb),
      .sync_ref_drive_en_out(drv), .output_clock_reset_input_in(pin_in),
      .output_clock_reset_out(orst));
   // ************************************************
   // register port and helpers
   // ************************************************
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      reg_wr_in <= 1; reg_addr_in <= a; reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 0;
   endtask : wr
   // write then read back on the very next strobe, no idle cycle between
   task wr_rd(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      reg_wr_in <= 1; reg_addr_in <= a; reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 0; reg_rd_in <= 1;
      @(posedge mclk_in);
      reg_rd_in <= 0;
      #1;
      `CHK("wr_rd", d, rdata)
   endtask : wr_rd
   // read data stands only in the cycle after the strobe, so look right there
   task rd(input logic [3:0] a, input logic [15:0] ex);
      @(posedge mclk_in);
      reg_rd_in <= 1; reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 0;
      #1;
      `CHK("rdata", ex, rdata)
   endtask : rd
   task settle();
      repeat (3) @(posedge mclk_in);
      #1;
   endtask : settle
   logic pat [5] = '{1, 1, 0, 0, 1};
   task div_check();
      logic prev;
      prev = 1;
      // step off the edge so the first look is not racing the flops
      #1;
      for (int i = 0; i < 8 && !(ra === 1 && prev === 0); i++)
      begin
         prev = ra;
         @(posedge mclk_in);
         #1;
      end
      foreach (pat[i])
      begin
         `CHK("ref_a", pat[i], ra)
         `CHK("ref_b", pat[i], rb)
         `CHK("drive", 1'b1, drv)
         @(posedge mclk_in);
         #1;
      end
   endtask : div_check
   // ************************************************
   // scenarios
   // ************************************************
   task t_reset();
      #1;
      `CHK("master", 1'b1, mst)
      `CHK("drive", 1'b0, drv)
      `CHK("orst", 1'b0, orst)
      rd(ADSC_FINE_OFFSET, ADSC_FINE_RESET);
      rd(ADSC_SYNC_OFFSET, ADSC_SYNC_RESET);
      wr(4'h3, 16'hFFFF);
      rd(4'h3, 16'h0000);
      rd(ADSC_SYNC_OFFSET, ADSC_SYNC_RESET);
      $display("test reset done");
   endtask : t_reset
   task t_aperture();
      @(posedge mclk_in);
      cc_in <= 12'hABC;
      wr(ADSC_FINE_OFFSET, 16'hA800);
      settle();
      `CHK("act", 1'b0, act)
      `CHK("fine", 6'h00, fn_ap)
      @(posedge mclk_in);
      en_in <= 1;
      settle();
      `CHK("act", 1'b1, act)
      `CHK("coarse", 12'hABC, cc_ap)
      `CHK("fine", 6'h2A, fn_ap)
      @(posedge mclk_in);
      en_in <= 0;
      wr(ADSC_FINE_OFFSET, 16'hA900);
      settle();
      `CHK("act", 1'b1, act)
      `CHK("coarse", 12'hABC, cc_ap)
      `CHK("fine", 6'h2A, fn_ap)
      rd(ADSC_FINE_OFFSET, 16'hA900);
      wr(ADSC_FINE_OFFSET, 16'h0000);
      settle();
      `CHK("act", 1'b0, act)
      `CHK("fine", 6'h00, fn_ap)
      $display("test aperture done");
   endtask : t_aperture
   task automatic t_refdly();
      int codes [6] = '{0, 1, 160, 318, 319, 511};
      int cl;
      foreach (codes[i])
      begin
         cl = (codes[i] > 319) ? 319 : codes[i];
         wr_rd(ADSC_SYNC_OFFSET, {9'(codes[i]), 7'h03});
         settle();
         `CHK("dly", 9'(cl), dly)
         `CHK("ps", 11'(cl * 1200 / 319), ps)
      end
      $display("test ref delay done");
   endtask : t_refdly
   task automatic t_mode();
      logic [8:0] deg [4] = '{ADSC_DEG_0, ADSC_DEG_90, ADSC_DEG_180, ADSC_DEG_270};
      logic [15:0] d;
      // dual-edge mode also needs bits 7:5 at address zero cleared
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0000);
      for (int p = 0; p < 4; p++)
      begin
         d = 16'h0003 | 16'(p << 3) | 16'(p[0] << 6) | 16'(p[1] << 2);
         wr(ADSC_SYNC_OFFSET, d);
         settle();
         `CHK("psel", 2'(p), psel)
         `CHK("pdeg", deg[p], pdeg)
         `CHK("dual", p[0], dual)
         `CHK("qdeg", p[0] ? ADSC_DEG_180 : ADSC_DEG_0, qdeg)
         `CHK("flw", p[1], flw)
         `CHK("master", !p[1], mst)
         rd(ADSC_SYNC_OFFSET, d);
      end
      $display("test mode done");
   endtask : t_mode
   task t_refout();
      wr(ADSC_SYNC_OFFSET, 16'h0005);
      div_check();
      wr(ADSC_SYNC_OFFSET, 16'h0001);
      div_check();
      wr(ADSC_SYNC_OFFSET, 16'h0003);
      settle();
      `CHK("drive", 1'b0, drv)
      `CHK("ref_a", 1'b0, ra)
      `CHK("ref_b", 1'b0, rb)
      $display("test ref out done");
   endtask : t_refout
   task t_rstpin();
      wr(ADSC_SYNC_OFFSET, 16'h0002);
      @(posedge mclk_in);
      pin_in <= 1;
      repeat (4) @(posedge mclk_in);
      #1;
      `CHK("orst", 1'b1, orst)
      wr(ADSC_SYNC_OFFSET, 16'h0003);
      settle();
      `CHK("orst", 1'b0, orst)
      @(posedge mclk_in);
      pin_in <= 0;
      $display("test reset pin done");
   endtask : t_rstpin
   // reset in mid-run must bring back the power-on register values
   task t_midreset();
      wr(ADSC_SYNC_OFFSET, 16'h0004);
      wr(ADSC_FINE_OFFSET, 16'hFC00);
      @(posedge mclk_in);
      nrst_in <= 0;
      repeat (3) @(posedge mclk_in);
      nrst_in <= 1;
      #1;
      `CHK("master", 1'b1, mst)
      `CHK("flw", 1'b0, flw)
      rd(ADSC_FINE_OFFSET, ADSC_FINE_RESET);
      rd(ADSC_SYNC_OFFSET, ADSC_SYNC_RESET);
      $display("test mid reset done");
   endtask : t_midreset
   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (12) @(posedge mclk_in);
      nrst_in <= 1;
      t_reset();
      t_aperture();
      t_refdly();
      t_mode();
      t_refout();
      t_rstpin();
      t_midreset();
      tally_and_finish();
   end
   // the whole run needs well under 1000 cycles
   initial
   begin
      #20000;
      num_errors++;
      tally_and_finish();
   end
endmodule : tb_adsc_top
